// file: sync_timing_map.svh
// register offsets, field positions, reset values and timing counts
// assumes an 8 ns system clock and 16-bit registers on a 3-bit index
`ifndef SYNC_TIMING_MAP_SVH
`define SYNC_TIMING_MAP_SVH
`define OFF_SYNC_CONTROL 3'h0
`define OFF_SYNC_CONTROL_TWO 3'h1
`define OFF_FRAME_LINE_COUNT 3'h2
`define OFF_HORIZONTAL_PERIOD 3'h3
`define OFF_VERTICAL_LAYER_DELAY 3'h4
`define OFF_HORIZONTAL_LAYER_DELAY 3'h5
`define RST_SYNC_CONTROL 16'h0000
`define RST_SYNC_CONTROL_TWO 16'h0011
`define RST_FRAME_LINE_COUNT 16'h0271
`define RST_HORIZONTAL_PERIOD 16'h0855
`define RST_VERTICAL_LAYER_DELAY 16'h0020
`define RST_HORIZONTAL_LAYER_DELAY 16'h0020
`define MASK_SYNC_CONTROL_TWO 16'h077F
`define MASK_10 16'h03FF
`define MASK_12 16'h0FFF
`define SCR_ROLE 0
`define SCR_COMPOSITE 1
`define SCR_SCAN 2
`define SCR_VPOL 3
`define SCR_HPOL 4
`define SCR_CPOL 5
`define SCR_BPOL 6
`define SCR_VSU_MID_LO 7
`define SCR_VSU_MID_HI 10
`define SCR_THREE 11
`define SCR_VSU_B0 12
`define SCR_VSU_B5 13
`define SCR_DOUBLE_RES_ENABLE 14
`define SCR_FIELD_INVERT 15
`define SYNC_CONTROL_TWO_SECOND_SAMPLE_DELAY_HI 5
`define SYNC_CONTROL_TWO_FIELD_PIN_OUTPUT_ENABLE 6
`define SYNC_CONTROL_TWO_DETECTED_FIELD_FLAG 7
`define SYNC_CONTROL_TWO_FOFF_LO 8
`define SYNC_CONTROL_TWO_FOFF_HI 10
`define CLK_PERIOD_NS 8
`define LINE_STEP_NS 30
`define HALF_STEP_NS (`LINE_STEP_NS / 2)
`define TAP_STEP_NS 1920
`define TAP_STEP_CYC ((`TAP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HSYNC_NS 4700
`define EQ_NS 2350
`define VSYNC_HALVES 5
`define EQ_HALVES 5
`endif

// file: sync_timing_pkg.sv
// state types of the sync timing unit and its vsync sampling taps
// assumes the map header for all numeric constants
package sync_timing_pkg;
  typedef struct packed {
    logic busy;
    logic [5:0] step;
    logic [7:0] cyc;
    logic sample;
    logic done;
  } tap_state_t;
  typedef struct packed {
    logic [15:0] sync_control;
    logic [15:0] sync_control_two;
    logic [15:0] frame_line_count;
    logic [15:0] horizontal_period;
    logic [15:0] vertical_layer_delay;
    logic [15:0] horizontal_layer_delay;
    logic [15:0] rd_data;
    logic role_q;
    logic [16:0] hns;
    logic [10:0] hc;
    logic line_phase;
    logic h_s1;
    logic h_s2;
    logic v_s1;
    logic v_s2;
    logic h_prev;
    logic v_prev;
    logic s1_prev;
    logic field;
    logic [9:0] line_cnt;
    logic [11:0] pix_cnt;
    logic pix_run;
    logic h_pin_out;
    logic h_pin_oe;
    logic v_pin_out;
    logic v_pin_oe;
    logic blank_pin;
    logic contrast_pin;
    logic [1:0] blank_level;
    logic field_pin_out;
    logic field_pin_oe;
    logic field_parity;
    logic double_res;
    logic [2:0] alpha_line_offset;
    logic h_event;
    logic v_event;
    logic layer_line_start;
    logic layer_pixel_start;
  } sync_state_t;
endpackage : sync_timing_pkg

// file: vsync_tap.sv
// one vsync sampling point: waits delay steps after start, then latches
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`include "sync_timing_map.svh"
module vsync_tap (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic [5:0] delay,
  input wire logic level,
  output logic sample,
  output logic done
);
  sync_timing_pkg::tap_state_t s;
  sync_timing_pkg::tap_state_t n;
  // a new start restarts the wait; a line shorter than the delay never samples
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (start) begin
      n.busy = 1'b1;
      n.step = delay;
      n.cyc = 8'h00;
    end else if (s.busy) begin
      if (s.step == 6'h00) begin
        n.busy = 1'b0;
        n.sample = level;
        n.done = 1'b1;
      end else if (s.cyc == 8'(`TAP_STEP_CYC - 1)) begin
        n.cyc = 8'h00;
        n.step = s.step - 6'h01;
      end else begin
        n.cyc = s.cyc + 8'h01;
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
  assign sample = s.sample;
  assign done = s.done;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);
  property p_tap_one_step;
    (start && delay == 6'h01) ##1 !start[*8] |-> ##[232:236] done;
  endproperty
  a_tap_one_step: assert property (p_tap_one_step) else $error("tap delay wrong");
  property p_tap_zero;
    (start && delay == 6'h00) |=> ##1 done;
  endproperty
  a_tap_zero: assert property (p_tap_zero) else $error("zero tap delay wrong");
endmodule : vsync_tap

// file: sync_timing_unit.sv
// display sync timing unit: master sync generator, slave sync input,
// field detection, layer 1 offsets and blanking/contrast pin output
// assumes a 125 MHz clock, pixel_tick on the same clock, and a register
// port with read data in the cycle after the read strobe
// How it works
// - role bit 0 makes H/V pins inputs, 1 makes them driven outputs
// - switching slave to master resets the horizontal and vertical counters
// - in slave role line count and period registers do not affect timing
// - composite bit 1 puts H, V and equalizing pulses on the V pin
// - scan bit 0 interlaced, 1 progressive; interlace needs odd line count
// - H and V pin polarity bits: 0 active high, 1 inverted
// - contrast polarity 0 active high, 1 inverted, not in three-level mode
// - blanking polarity 0 inverted, 1 active high, inversion not three-level
// - vsync latched at hsync edge plus 1.92 us times first delay
// - three-level mode codes blank and contrast as levels 0, 1, 2
// - double resolution passes field parity to the display unit
// - field invert flips the field only with port alternate select
// - a second vsync sample at 1.92 us times second delay
// - active at both samples means odd, first only means even
// - field pin enable routes field to the port pin, else port bit
// - detected field flag is hardware written, read only, 1 is even
// - alpha raster offset is a signed 3-bit line shift with double res
// - vsync every half line count interlaced, every full count otherwise
// - horizontal period is the period field times 30 ns
// - vertical layer delay counts lines from vsync to layer 1
// - horizontal layer delay counts pixels from hsync to layer 1
// - one-cycle events on the rising undelayed hsync and vsync
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "sync_timing_map.svh"
module sync_timing_unit (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic h_pin_in,
  output logic h_pin_out,
  output logic h_pin_oe,
  input wire logic v_pin_in,
  output logic v_pin_out,
  output logic v_pin_oe,
  input wire logic pixel_tick,
  input wire logic blank_req,
  input wire logic contrast_req,
  input wire logic port_pin_alt_select,
  input wire logic port_data,
  input wire logic port_dir,
  output logic blank_pin,
  output logic contrast_pin,
  output logic [1:0] blank_level,
  output logic field_pin_out,
  output logic field_pin_oe,
  output logic field_parity,
  output logic double_res,
  output logic [2:0] alpha_line_offset,
  output logic h_event,
  output logic v_event,
  output logic layer_line_start,
  output logic layer_pixel_start
);
  sync_timing_pkg::sync_state_t s;
  sync_timing_pkg::sync_state_t n;
  // ****************************************
  // control decode
  // ****************************************
  logic sync_role_select;
  logic composite;
  logic interlaced;
  logic vertical_pin_polarity;
  logic horizontal_pin_polarity;
  logic contrast_pin_polarity;
  logic blanking_pin_polarity;
  logic three_level_mode;
  logic double_res_enable;
  logic field_invert;
  logic field_pin_output_enable;
  logic [5:0] vertical_sample_delay;
  logic [5:0] second_sample_delay;
  logic [16:0] half_target;
  logic [17:0] hns_over;
  logic [10:0] field_len;
  logic half_end;
  logic gen_h;
  logic gen_v;
  logic eq_zone;
  logic comp;
  logic cur_h;
  logic cur_v;
  logic h_rise;
  logic v_rise;
  logic tap1;
  logic tap2;
  logic field_sig;
  logic [9:0] next_line;
  assign sync_role_select = s.sync_control[`SCR_ROLE];
  assign composite = s.sync_control[`SCR_COMPOSITE];
  // even line counts cannot interlace, so they fall back to progressive
  assign interlaced = !s.sync_control[`SCR_SCAN] && s.frame_line_count[0];
  assign vertical_pin_polarity = s.sync_control[`SCR_VPOL];
  assign horizontal_pin_polarity = s.sync_control[`SCR_HPOL];
  assign contrast_pin_polarity = s.sync_control[`SCR_CPOL];
  assign blanking_pin_polarity = s.sync_control[`SCR_BPOL];
  assign three_level_mode = s.sync_control[`SCR_THREE];
  assign double_res_enable = s.sync_control[`SCR_DOUBLE_RES_ENABLE];
  assign field_invert = s.sync_control[`SCR_FIELD_INVERT];
  assign field_pin_output_enable = s.sync_control_two[`SYNC_CONTROL_TWO_FIELD_PIN_OUTPUT_ENABLE];
  assign vertical_sample_delay = {s.sync_control[`SCR_VSU_B5],
    s.sync_control[`SCR_VSU_MID_HI:`SCR_VSU_MID_LO], s.sync_control[`SCR_VSU_B0]};
  assign second_sample_delay = s.sync_control_two[`SYNC_CONTROL_TWO_SECOND_SAMPLE_DELAY_HI:0];
  // ****************************************
  // master timebase in half lines
  // ****************************************
  // counting nanoseconds keeps the 30 ns step exact on average
  assign half_target = {5'h00, s.horizontal_period[11:0]} * 17'(`HALF_STEP_NS);
  assign half_end = ({1'b0, s.hns} + 18'(`CLK_PERIOD_NS)) >= {1'b0, half_target};
  assign hns_over = ({1'b0, s.hns} + 18'(`CLK_PERIOD_NS)) - {1'b0, half_target};
  assign field_len = interlaced ? {1'b0, s.frame_line_count[9:0]} : {s.frame_line_count[9:0], 1'b0};
  assign gen_h = sync_role_select && !s.line_phase && (s.hns < 17'(`HSYNC_NS));
  assign gen_v = sync_role_select && (s.hc < 11'(`VSYNC_HALVES));
  assign eq_zone = (s.hc < 11'(`VSYNC_HALVES + `EQ_HALVES)) ||
    ((s.hc + 11'(`EQ_HALVES)) >= field_len);
  // broad pulses serrated at each half line, short pulses around them
  assign comp = gen_v ? ((s.hns + 17'(`HSYNC_NS)) < half_target) :
    (eq_zone ? (s.hns < 17'(`EQ_NS)) : gen_h);
  // ****************************************
  // internal sync, normal polarity
  // ****************************************
  assign cur_h = sync_role_select ? gen_h : (s.h_s2 ^ horizontal_pin_polarity);
  assign cur_v = sync_role_select ? gen_v : (s.v_s2 ^ vertical_pin_polarity);
  assign h_rise = cur_h && !s.h_prev;
  assign v_rise = cur_v && !s.v_prev;
  assign field_sig = s.field ^ (field_invert && port_pin_alt_select);
  assign next_line = (tap1 && !s.s1_prev) ? 10'h000 :
    ((s.line_cnt == 10'h3FF) ? s.line_cnt : s.line_cnt + 10'h001);
  vsync_tap first_tap (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(h_rise),
    .delay(vertical_sample_delay),
    .level(cur_v),
    .sample(tap1),
    .done()
  );
  vsync_tap second_tap (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(h_rise),
    .delay(second_sample_delay),
    .level(cur_v),
    .sample(tap2),
    .done()
  );
  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.rd_data = 16'h0000;
    n.h_event = 1'b0;
    n.v_event = 1'b0;
    n.layer_line_start = 1'b0;
    n.layer_pixel_start = 1'b0;
    if (wr_en) begin
      case (addr)
        `OFF_SYNC_CONTROL: n.sync_control = wr_data;
        `OFF_SYNC_CONTROL_TWO: n.sync_control_two = wr_data & `MASK_SYNC_CONTROL_TWO;
        `OFF_FRAME_LINE_COUNT: n.frame_line_count = wr_data & `MASK_10;
        `OFF_HORIZONTAL_PERIOD: n.horizontal_period = wr_data & `MASK_12;
        `OFF_VERTICAL_LAYER_DELAY: n.vertical_layer_delay = wr_data & `MASK_10;
        `OFF_HORIZONTAL_LAYER_DELAY: n.horizontal_layer_delay = wr_data & `MASK_12;
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        `OFF_SYNC_CONTROL: n.rd_data = s.sync_control;
        `OFF_SYNC_CONTROL_TWO: begin
          n.rd_data = s.sync_control_two;
          n.rd_data[`SYNC_CONTROL_TWO_DETECTED_FIELD_FLAG] = s.field;
        end
        `OFF_FRAME_LINE_COUNT: n.rd_data = s.frame_line_count;
        `OFF_HORIZONTAL_PERIOD: n.rd_data = s.horizontal_period;
        `OFF_VERTICAL_LAYER_DELAY: n.rd_data = s.vertical_layer_delay;
        `OFF_HORIZONTAL_LAYER_DELAY: n.rd_data = s.horizontal_layer_delay;
        default: n.rd_data = 16'h0000;
      endcase
    end
    n.h_s1 = h_pin_in;
    n.h_s2 = s.h_s1;
    n.v_s1 = v_pin_in;
    n.v_s2 = s.v_s1;
    n.role_q = sync_role_select;
    if (!sync_role_select) begin
      n.hns = 17'h00000;
      n.hc = 11'h000;
      n.line_phase = 1'b0;
    end else if (!s.role_q) begin
      n.hns = 17'h00000;
      n.hc = 11'h000;
      n.line_phase = 1'b0;
    end else if (half_end) begin
      // carry the overshoot; a shrunk target restarts from zero
      n.hns = (hns_over < 18'(`CLK_PERIOD_NS)) ? hns_over[16:0] : 17'h00000;
      n.line_phase = !s.line_phase;
      if ((s.hc + 11'h001) >= field_len) begin
        n.hc = 11'h000;
      end else begin
        n.hc = s.hc + 11'h001;
      end
    end else begin
      n.hns = s.hns + 17'(`CLK_PERIOD_NS);
    end
    n.h_pin_oe = sync_role_select;
    n.v_pin_oe = sync_role_select;
    n.h_pin_out = gen_h ^ horizontal_pin_polarity;
    n.v_pin_out = (composite ? comp : gen_v) ^ vertical_pin_polarity;
    n.h_prev = cur_h;
    n.v_prev = cur_v;
    n.h_event = h_rise;
    n.v_event = v_rise;
    if (h_rise) begin
      n.s1_prev = tap1;
      if (tap1 && !s.s1_prev) begin
        n.field = !tap2;
      end
      n.line_cnt = next_line;
      n.layer_line_start = (next_line == s.vertical_layer_delay[9:0]);
      n.pix_cnt = 12'h000;
      n.pix_run = (next_line >= s.vertical_layer_delay[9:0]);
    end else if (s.pix_run && pixel_tick) begin
      if ((s.pix_cnt + 12'h001) >= s.horizontal_layer_delay[11:0]) begin
        n.layer_pixel_start = 1'b1;
        n.pix_run = 1'b0;
      end else begin
        n.pix_cnt = s.pix_cnt + 12'h001;
      end
    end
    n.double_res = double_res_enable;
    n.field_parity = double_res_enable && field_sig;
    n.alpha_line_offset = double_res_enable ?
      s.sync_control_two[`SYNC_CONTROL_TWO_FOFF_HI:`SYNC_CONTROL_TWO_FOFF_LO] : 3'h0;
    n.field_pin_out = field_pin_output_enable ? field_sig : port_data;
    n.field_pin_oe = field_pin_output_enable ? 1'b1 : port_dir;
    // polarity is ignored in three-level mode, where inversion is not allowed
    if (three_level_mode) begin
      n.blank_level = blank_req ? 2'h2 : (contrast_req ? 2'h1 : 2'h0);
      n.blank_pin = blank_req;
      n.contrast_pin = contrast_req && !blank_req;
    end else begin
      n.blank_level = {1'b0, blank_req ^ !blanking_pin_polarity};
      n.blank_pin = blank_req ^ !blanking_pin_polarity;
      n.contrast_pin = contrast_req ^ contrast_pin_polarity;
    end
  end
  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sync_control <= `RST_SYNC_CONTROL;
      s.sync_control_two <= `RST_SYNC_CONTROL_TWO;
      s.frame_line_count <= `RST_FRAME_LINE_COUNT;
      s.horizontal_period <= `RST_HORIZONTAL_PERIOD;
      s.vertical_layer_delay <= `RST_VERTICAL_LAYER_DELAY;
      s.horizontal_layer_delay <= `RST_HORIZONTAL_LAYER_DELAY;
    end else if (ce) begin
      s <= n;
    end
  end
  assign rd_data = s.rd_data;
  assign h_pin_out = s.h_pin_out;
  assign h_pin_oe = s.h_pin_oe;
  assign v_pin_out = s.v_pin_out;
  assign v_pin_oe = s.v_pin_oe;
  assign blank_pin = s.blank_pin;
  assign contrast_pin = s.contrast_pin;
  assign blank_level = s.blank_level;
  assign field_pin_out = s.field_pin_out;
  assign field_pin_oe = s.field_pin_oe;
  assign field_parity = s.field_parity;
  assign double_res = s.double_res;
  assign alpha_line_offset = s.alpha_line_offset;
  assign h_event = s.h_event;
  assign v_event = s.v_event;
  assign layer_line_start = s.layer_line_start;
  assign layer_pixel_start = s.layer_pixel_start;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);
  property p_role_drive;
    1'b1 |=> (h_pin_oe == $past(sync_role_select)) && (v_pin_oe == h_pin_oe);
  endproperty
  a_role_drive: assert property (p_role_drive) else $error("pin drive wrong");
  property p_switch_reset;
    (sync_role_select && !s.role_q) |=> (s.hns == 17'h00000) && (s.hc == 11'h000);
  endproperty
  a_switch_reset: assert property (p_switch_reset) else $error("no reset");
  property p_slave_idle;
    !sync_role_select |=> (s.hns == 17'h00000) && !h_pin_oe;
  endproperty
  a_slave_idle: assert property (p_slave_idle) else $error("slave counts");
  property p_field_wrap;
    (sync_role_select && s.role_q && half_end && (s.hc + 11'h001) >= field_len)
      |=> (s.hc == 11'h000) ##1 v_event;
  endproperty
  a_field_wrap: assert property (p_field_wrap) else $error("field wrap wrong");
  property p_three_blank;
    (three_level_mode && blank_req) |=> (blank_level == 2'h2) && blank_pin;
  endproperty
  a_three_blank: assert property (p_three_blank) else $error("level 2 wrong");
  property p_three_cor;
    (three_level_mode && !blank_req && contrast_req) |=> blank_level == 2'h1;
  endproperty
  a_three_cor: assert property (p_three_cor) else $error("level 1 wrong");
  property p_field_out;
    1'b1 |=> field_parity == $past(double_res_enable &&
      (s.field ^ (field_invert && port_pin_alt_select)));
  endproperty
  a_field_out: assert property (p_field_out) else $error("field parity wrong");
  property p_field_pin;
    field_pin_output_enable |=> field_pin_oe && (field_pin_out == $past(field_sig));
  endproperty
  a_field_pin: assert property (p_field_pin) else $error("field pin wrong");
  property p_field_hw;
    $changed(s.field) |-> $past(h_rise);
  endproperty
  a_field_hw: assert property (p_field_hw) else $error("field flag moved");
  property p_h_event;
    h_event |-> $past(cur_h) && !$past(s.h_prev) ##1 !h_event;
  endproperty
  a_h_event: assert property (p_h_event) else $error("h event wrong");
  c_switch: cover property (sync_role_select && !s.role_q);
  c_even: cover property (h_rise && tap1 && !s.s1_prev && !tap2);
  c_three: cover property (three_level_mode && blank_level == 2'h2);
  c_pixel: cover property (layer_pixel_start);
endmodule : sync_timing_unit

// file: sync_source.sv
// far-side sync source: separate h and v pins for the slave role
// assumes the unit's clock; pins change just after a rising edge
`timescale 1ns/1ps
module sync_source (
  input wire logic clk,
  input wire logic run,
  input wire logic h_inv,
  input wire logic [15:0] v_start,
  output logic h_pin,
  output logic v_pin,
  output logic line_mark
);
  // ****
  // line of 1000 cycles, frame of 6 lines
  // ****
  localparam int LINE = 1000;
  localparam int FRAME = 6000;
  int fp = 0;
  initial begin
    h_pin = 1'b0;
    v_pin = 1'b0;
    line_mark = 1'b0;
  end
  // pins idle at the inactive level while stopped, never floating
  always @(posedge clk) begin
    fp <= (!run || fp == FRAME - 1) ? 0 : fp + 1;
    line_mark <= run && (fp % LINE == 0);
    h_pin <= h_inv ^ (run && (fp % LINE) < 40);
    v_pin <= run && fp >= int'(v_start) && fp < int'(v_start) + 4 * LINE;
  end
endmodule : sync_source

// file: sync_timing_unit_tb_top.sv
// self-checking bench for the display sync timing unit
// assumes the map header and the sync_source model on the h/v pins
`timescale 1ns/1ps
`include "sync_timing_map.svh"
module sync_timing_unit_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr_en = 1'b0, rd_en = 1'b0, pixel_tick = 1'b0;
  logic blank_req = 1'b0, contrast_req = 1'b0, port_pin_alt_select = 1'b0;
  logic port_data = 1'b0, port_dir = 1'b1, src_run = 1'b0, src_hinv = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wr_data = 16'h0000, src_vstart = 16'h00C8;
  logic [15:0] rd_data;
  logic [1:0] blank_level;
  logic [2:0] alpha_line_offset;
  logic h_pin_in, v_pin_in, line_mark, h_pin_out, h_pin_oe, v_pin_out, v_pin_oe;
  logic blank_pin, contrast_pin, field_pin_out, field_pin_oe, field_parity;
  logic double_res, h_event, v_event, layer_line_start, layer_pixel_start;
  int n_mismatch = 0;
  int check_count = 0;

  sync_timing_unit i_sync_timing_unit (
    .clk, .rst, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .h_pin_in, .h_pin_out, .h_pin_oe, .v_pin_in, .v_pin_out, .v_pin_oe,
    .pixel_tick, .blank_req, .contrast_req, .port_pin_alt_select,
    .port_data, .port_dir, .blank_pin, .contrast_pin, .blank_level,
    .field_pin_out, .field_pin_oe, .field_parity, .double_res,
    .alpha_line_offset, .h_event, .v_event, .layer_line_start,
    .layer_pixel_start
  );
  sync_source i_sync_source (.clk(clk), .run(src_run), .h_inv(src_hinv),
    .v_start(src_vstart), .h_pin(h_pin_in), .v_pin(v_pin_in), .line_mark(line_mark));

  initial begin
    forever #4 clk = ~clk;
  end
  always @(posedge clk) pixel_tick <= ~pixel_tick;

  // ****
  // bus, wait and compare tasks
  // ****
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  // counts cycles up to the next event; a missing event is a mismatch
  task automatic wait_ev(input bit v, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((v ? v_event : h_event) !== 1'b1 && n < 20000);
    if (n >= 20000) chk(16'h0000, 16'h0001);
  endtask : wait_ev

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  // ****
  // scenarios
  // ****
  task automatic t_regs;
    logic [15:0] d;
    logic [15:0] rv [6] = '{`RST_SYNC_CONTROL, `RST_SYNC_CONTROL_TWO,
      `RST_FRAME_LINE_COUNT, `RST_HORIZONTAL_PERIOD,
      `RST_VERTICAL_LAYER_DELAY, `RST_HORIZONTAL_LAYER_DELAY};
    logic [15:0] m [6] = '{16'hFFFF, 16'h077F, 16'h03FF, 16'h0FFF, 16'h03FF, 16'h0FFF};
    for (int i = 0; i < 6; i++) begin
      rd(3'(i), d);
      chk(d, rv[i]);
    end
    for (int i = 7; i >= 0; i--) wr(3'(i), 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), d);
      chk(d, i < 6 ? m[i] : 16'h0000);
    end
    for (int i = 0; i < 6; i++) wr(3'(i), rv[i]);
    $display("regs test done");
  endtask : t_regs

  task automatic t_blank;
    logic [15:0] cf [3] = '{16'h0040, 16'h0020, 16'h0840};
    logic b, c, tl, eb, ec;
    logic [1:0] el;
    for (int s = 0; s < 3; s++) begin
      wr(`OFF_SYNC_CONTROL, cf[s]);
      for (int r = 0; r < 4; r++) begin
        b = r[1];
        c = r[0];
        @(posedge clk);
        blank_req <= b;
        contrast_req <= c;
        settle();
        tl = cf[s][11];
        eb = tl ? b : b ^ !cf[s][6];
        ec = tl ? c & !b : c ^ cf[s][5];
        el = tl ? (b ? 2'h2 : {1'b0, c}) : {1'b0, eb};
        chk(16'(blank_pin), 16'(eb));
        chk(16'(contrast_pin), 16'(ec));
        chk(16'(blank_level), 16'(el));
      end
    end
    $display("blank test done");
  endtask : t_blank

  task automatic t_master;
    logic [15:0] cf [3] = '{16'h0005, 16'h001D, 16'h0001};
    logic [15:0] vl [3] = '{16'h0004, 16'h0004, 16'h0007};
    logic [15:0] ev [3] = '{16'h0BB8, 16'h0BB8, 16'h0A41};
    int n;
    wr(`OFF_HORIZONTAL_PERIOD, 16'h00C8);
    for (int i = 0; i < 3; i++) begin
      wr(`OFF_FRAME_LINE_COUNT, vl[i]);
      wr(`OFF_SYNC_CONTROL, cf[i]);
      repeat (3) wait_ev(1'b1, n);
      chk(16'(n), ev[i]);
      repeat (10) @(posedge clk);
      #1;
      chk(16'(v_pin_out), 16'(!cf[i][3]));
      repeat (2) wait_ev(1'b0, n);
      chk(16'(n), 16'h02EE);
      repeat (10) @(posedge clk);
      #1;
      chk(16'({h_pin_out, h_pin_oe, v_pin_oe}), 16'({!cf[i][4], 2'b11}));
    end
    $display("master test done");
  endtask : t_master

  task automatic t_field(input logic [15:0] vs, input logic e);
    int n;
    logic [15:0] d;
    src_vstart <= vs;
    repeat (2) wait_ev(1'b1, n);
    repeat (2) wait_ev(1'b0, n);
    settle();
    rd(`OFF_SYNC_CONTROL_TWO, d);
    chk(d & 16'h0080, {8'h00, e, 7'h00});
    wr(`OFF_SYNC_CONTROL, 16'h4080);
    wr(`OFF_SYNC_CONTROL_TWO, 16'h0440);
    settle();
    chk(16'({field_parity, field_pin_out, field_pin_oe}), 16'({e, e, 1'b1}));
    chk(16'({double_res, alpha_line_offset}), 16'h000C);
    wr(`OFF_SYNC_CONTROL, 16'hC080);
    settle();
    chk(16'(field_parity), 16'(e));
    @(posedge clk);
    port_pin_alt_select <= 1'b1;
    settle();
    chk(16'(field_parity), 16'(!e));
    wr(`OFF_SYNC_CONTROL, 16'h0080);
    wr(`OFF_SYNC_CONTROL_TWO, 16'h0000);
    port_pin_alt_select <= 1'b0;
    port_data <= 1'b1;
    port_dir <= 1'b0;
    settle();
    chk(16'({field_parity, field_pin_out, field_pin_oe, double_res, alpha_line_offset}),
      16'h0020);
  endtask : t_field

  task automatic t_slave;
    int n;
    wr(`OFF_SYNC_CONTROL_TWO, 16'h0000);
    wr(`OFF_HORIZONTAL_PERIOD, 16'h0010);
    src_run <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(`OFF_SYNC_CONTROL, i ? 16'h0090 : 16'h0080);
      src_hinv <= i[0];
      do begin
        @(posedge clk);
        #1;
      end while (line_mark !== 1'b1);
      wait_ev(1'b0, n);
      chk(16'(n), 16'h0003);
      wait_ev(1'b0, n);
      chk(16'(n), 16'h03E8);
      chk(16'({h_pin_oe, v_pin_oe}), 16'h0000);
    end
    wr(`OFF_SYNC_CONTROL, 16'h0080);
    src_hinv <= 1'b0;
    // tap two early, tap one late: an early v rise reads as even, a late one as odd
    t_field(16'h00C8, 1'b1);
    t_field(16'h0384, 1'b0);
    $display("slave test done");
  endtask : t_slave

  // frozen enable holds read data and drops strobes; run while timing is idle
  task automatic t_hold;
    logic [15:0] d;
    @(posedge clk);
    addr <= `OFF_FRAME_LINE_COUNT;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    ce <= 1'b0;
    wr_en <= 1'b1;
    wr_data <= 16'h0123;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(rd_data, `RST_FRAME_LINE_COUNT);
    @(posedge clk);
    ce <= 1'b1;
    rd(`OFF_FRAME_LINE_COUNT, d);
    chk(d, `RST_FRAME_LINE_COUNT);
    $display("hold test done");
  endtask : t_hold

  task automatic t_layer;
    int n;
    int k;
    wr(`OFF_SYNC_CONTROL, 16'h1000);
    wr(`OFF_VERTICAL_LAYER_DELAY, 16'h0002);
    wr(`OFF_HORIZONTAL_LAYER_DELAY, 16'h0004);
    wait_ev(1'b1, n);
    n = 0;
    k = 0;
    // vsync rises after the first sample, so line 0 starts a line later
    do begin
      @(posedge clk);
      #1;
      n += int'(h_event);
      k++;
    end while (layer_line_start !== 1'b1 && k < 5000);
    chk(16'(n), 16'h0004);
    n = 0;
    do begin
      n += int'(pixel_tick);
      @(posedge clk);
      #1;
      k++;
    end while (layer_pixel_start !== 1'b1 && k < 10000);
    chk(16'(n), 16'h0004);
    $display("layer test done");
  endtask : t_layer

  // ****
  // run control
  // ****
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_hold();
    t_blank();
    t_master();
    t_slave();
    t_layer();
    conclude();
  end

  // tests need about 60000 cycles
  initial begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule : sync_timing_unit_tb_top
